// ==== rtl/sirq_host.sv ====
// Host end of the serial interrupt link, with an Avalon-MM register slave.
// Assumes devices on the link follow the slot timing of the device end.
`default_nettype none

module sirq_host (
  // Clock, reset, freeze
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Collected levels
  output logic [17:1]      irq_levels_o,
  output logic             cycle_done_o,
  // Link
  sirq_if.host             sirq
);

  // ==========================================================================
  // Declarations
  wire logic        line;
  wire logic [2:0]  extra;
  wire logic [3:0]  start_w;
  wire logic [3:0]  stop_w;
  wire logic        slave_start;
  wire logic        own_start;
  wire logic [4:0]  frame_n;
  wire logic        rd_wait;
  wire logic        wr_ctrl;
  wire logic [31:0] ctrl_val;
  wire logic [31:0] stat_val;
  wire logic [31:0] rd_val;
  wire logic        take;

  sirq_pkg::sirq_host_state_t state_q;
  sirq_pkg::sirq_host_state_t state_d;
  sirq_pkg::sirq_phase_t      phase_q;
  sirq_pkg::sirq_phase_t      phase_d;

  logic [4:0]  frame_q;
  logic [4:0]  frame_d;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  logic        oe_q;
  logic        oe_d;
  logic        do_q;
  logic        do_d;
  logic        mode_q;
  logic        mode_d;
  logic        sel_q;
  logic        sel_d;
  logic        done_d;
  logic        done_q;
  logic [17:1] lvl_q;
  logic        go_q;
  logic        init_q;
  logic        quiet_q;
  logic        auto_q;
  logic [2:0]  extra_q;
  logic        ack_q;
  logic [31:0] rdata_q;

  // ==========================================================================
  // Decode
  assign line        = sirq.line;
  assign extra       = (extra_q < sirq_pkg::EXTRA_MIN) ? sirq_pkg::EXTRA_MIN : extra_q;
  assign start_w     = {1'b0, extra} + 4'h1;
  assign stop_w      = sel_q ? sirq_pkg::STOP_Q_W : sirq_pkg::STOP_C_W;
  assign slave_start = mode_q & ~line;
  assign own_start   = go_q | init_q | auto_q;
  assign frame_n     = sirq_pkg::frame_inc(frame_q);
  assign take        = (state_q == sirq_pkg::H_IDLE) && (state_d == sirq_pkg::H_START);
  assign rd_wait     = avs_read_i & ~ack_q;
  assign wr_ctrl     = avs_write_i && (avs_address_i == sirq_pkg::REG_CTRL);
  assign ctrl_val    = {25'h0, extra_q, 1'b0, auto_q, quiet_q, go_q};
  assign stat_val    = {30'h0, mode_q, (state_q != sirq_pkg::H_IDLE)};
  assign rd_val      = (avs_address_i == sirq_pkg::REG_CTRL)   ? ctrl_val :
                       (avs_address_i == sirq_pkg::REG_STATUS) ? stat_val :
                       (avs_address_i == sirq_pkg::REG_LEVELS) ? {14'h0, lvl_q, 1'b0} : 32'h0;

  // ==========================================================================
  // Cycle sequencer
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    frame_d = frame_q;
    cnt_d   = cnt_q;
    mode_d  = mode_q;
    sel_d   = sel_q;
    oe_d    = 1'b0;
    do_d    = 1'b0;
    done_d  = 1'b0;
    unique case (state_q)
      sirq_pkg::H_IDLE: begin
        // Idle starts at the stop rise, so a start lands two clocks later.
        if (slave_start) begin
          state_d = sirq_pkg::H_START;
          cnt_d   = sirq_pkg::SLV_FIRST;
          oe_d    = 1'b1;
        end else if (own_start) begin
          state_d = sirq_pkg::H_START;
          cnt_d   = sirq_pkg::OWN_FIRST;
          oe_d    = 1'b1;
        end
      end
      sirq_pkg::H_START: begin
        oe_d = 1'b1;
        if (cnt_q == start_w) begin
          state_d = sirq_pkg::H_START_HI;
          do_d    = 1'b1;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      sirq_pkg::H_START_HI: begin
        state_d = sirq_pkg::H_FRAMES;
        phase_d = sirq_pkg::PH_T;
        frame_d = 5'h00;
      end
      sirq_pkg::H_FRAMES: begin
        phase_d = sirq_pkg::next_phase(phase_q);
        if (phase_q == sirq_pkg::PH_T) begin
          frame_d = frame_n;
          if (frame_q == sirq_pkg::HOST_LAST) begin
            state_d = sirq_pkg::H_STOP;
            cnt_d   = sirq_pkg::OWN_FIRST;
            sel_d   = quiet_q;
            oe_d    = 1'b1;
          end
        end
      end
      sirq_pkg::H_STOP: begin
        oe_d = 1'b1;
        if (cnt_q == stop_w) begin
          state_d = sirq_pkg::H_STOP_HI;
          do_d    = 1'b1;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      sirq_pkg::H_STOP_HI: begin
        state_d = sirq_pkg::H_IDLE;
        mode_d  = sel_q;
        done_d  = 1'b1;
      end
      default: begin
        state_d = sirq_pkg::H_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= sirq_pkg::H_IDLE;
      phase_q <= sirq_pkg::PH_T;
      frame_q <= 5'h00;
      cnt_q   <= 4'h0;
      oe_q    <= 1'b0;
      do_q    <= 1'b0;
      mode_q  <= 1'b0;
      sel_q   <= 1'b0;
      done_q  <= 1'b0;
      lvl_q   <= 17'h1FFFF;
      init_q  <= 1'b1;
      go_q    <= 1'b0;
      quiet_q <= 1'b0;
      auto_q  <= 1'b0;
      extra_q <= sirq_pkg::EXTRA_RST;
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else if (ce_i) begin
      state_q <= state_d;
      phase_q <= phase_d;
      frame_q <= frame_d;
      cnt_q   <= cnt_d;
      oe_q    <= oe_d;
      do_q    <= do_d;
      mode_q  <= mode_d;
      sel_q   <= sel_d;
      done_q  <= done_d;
      if ((state_q == sirq_pkg::H_FRAMES) && (phase_q == sirq_pkg::PH_S) && (frame_q != 5'h00)) begin
        lvl_q[frame_q] <= line;
      end
      init_q <= init_q & ~take;
      // A write of the start bit wins over its clear in the same clock.
      go_q   <= (wr_ctrl & avs_writedata_i[sirq_pkg::CTRL_GO]) | (go_q & ~take);
      if (wr_ctrl) begin
        quiet_q <= avs_writedata_i[sirq_pkg::CTRL_QUIET];
        auto_q  <= avs_writedata_i[sirq_pkg::CTRL_AUTO];
        extra_q <= avs_writedata_i[sirq_pkg::CTRL_EXT +: 3];
      end
      ack_q <= rd_wait;
      if (rd_wait) begin
        rdata_q <= rd_val;
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign sirq.host_oe          = oe_q;
  assign sirq.host_do          = do_q;
  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = rd_wait;
  assign irq_levels_o      = lvl_q;
  assign cycle_done_o      = done_q;

endmodule

`default_nettype wire

// ==== rtl/sirq_pkg.sv ====
// Shared constants, types and helpers for the serial interrupt link.
// Assumes both ends run on the same PCI clock.
`default_nettype none

package sirq_pkg;

  // ==========================================================================
  // Frame layout
  localparam logic [4:0] SLOT_LAST   = 5'h10;
  localparam logic [4:0] HOST_LAST   = 5'h11;
  localparam logic [4:0] FRAME_SAT   = 5'h1F;
  localparam logic [1:0] STOP_QUIET  = 2'h2;
  localparam logic [1:0] LOW_SAT     = 2'h3;
  localparam logic [3:0] STOP_Q_W    = 4'h2;
  localparam logic [3:0] STOP_C_W    = 4'h3;
  localparam logic [2:0] EXTRA_MIN   = 3'h3;
  localparam logic [2:0] EXTRA_RST   = 3'h3;
  localparam logic [3:0] OWN_FIRST   = 4'h1;
  localparam logic [3:0] SLV_FIRST   = 4'h2;

  // ==========================================================================
  // Device side control bit positions
  localparam int unsigned EN_BIT        = 7;
  localparam int unsigned SMI_FRAME_BIT = 6;
  localparam int unsigned SMI_PIN_BIT   = 7;

  // ==========================================================================
  // Host register map and fields
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LEVELS = 4'h8;
  localparam int unsigned CTRL_GO    = 0;
  localparam int unsigned CTRL_QUIET = 1;
  localparam int unsigned CTRL_AUTO  = 2;
  localparam int unsigned CTRL_EXT   = 4;
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_QUIET = 1;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {PH_S = 2'h0, PH_R = 2'h1, PH_T = 2'h2} sirq_phase_t;
  typedef enum logic [1:0] {SL_IDLE = 2'h0, SL_START = 2'h1, SL_FRAMES = 2'h2} sirq_slv_state_t;
  typedef enum logic [2:0] {
    H_IDLE    = 3'h0,
    H_START   = 3'h1,
    H_START_HI = 3'h2,
    H_FRAMES  = 3'h3,
    H_STOP    = 3'h4,
    H_STOP_HI = 3'h5
  } sirq_host_state_t;

  // ==========================================================================
  // Helpers
  function automatic sirq_phase_t next_phase(input sirq_phase_t p);
    next_phase = (p == PH_S) ? PH_R : ((p == PH_R) ? PH_T : PH_S);
  endfunction

  function automatic logic [4:0] frame_inc(input logic [4:0] f);
    frame_inc = (f == FRAME_SAT) ? FRAME_SAT : f + 5'h01;
  endfunction

endpackage

`default_nettype wire

// ==== rtl/sirq_if.sv ====
// Shared serial interrupt line between the device end and the host end.
// Assumes an external pull-up: the line is high when nobody drives it low.
`default_nettype none

interface sirq_if;

  // ==========================================================================
  // Drivers and resolved level
  logic slv_oe;
  logic slv_do;
  logic host_oe;
  logic host_do;
  logic line;

  assign line = ~((slv_oe & ~slv_do) | (host_oe & ~host_do));

  modport slave (input line, output slv_oe, output slv_do);
  modport host  (input line, output host_oe, output host_do);

endinterface

`default_nettype wire

// ==== rtl/sirq_slave.sv ====
// Device end of the serial interrupt link: reports interrupt levels in slots.
// Assumes the host runs start and stop frames on the same clock.
`default_nettype none

module sirq_slave (
  // Clock, reset, freeze
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Configuration
  input  wire logic [7:0]  irq_routing_config_reg_i,
  input  wire logic [7:0]  smi_enable2_i,
  // Interrupt sources, high means inactive
  input  wire logic [15:1] irq_i,
  input  wire logic        system_mgmt_interrupt_n_i,
  // Status
  output logic             smi_output_pin_n_o,
  output logic             quiet_mode_o,
  output logic             cycle_active_o,
  // Link
  sirq_if.slave            sirq
);

  // ==========================================================================
  // Declarations
  wire logic        en;
  wire logic        line;
  wire logic        smi_to_frame;
  wire logic [16:1] lvl;
  wire logic        pend;
  wire logic        start_ok;
  wire logic [4:0]  frame_n;
  wire logic        slot_hit;
  wire logic        stop_seen;
  wire logic [1:0]  low_inc;
  wire logic        stop_quiet;
  wire logic        recover;
  wire logic        oe_gated;
  wire logic        rep_we;
  wire logic        smi_to_pin;
  wire logic        smi_d;

  sirq_pkg::sirq_slv_state_t state_q;
  sirq_pkg::sirq_slv_state_t state_d;
  sirq_pkg::sirq_phase_t     phase_q;
  sirq_pkg::sirq_phase_t     phase_d;

  logic [4:0]  frame_q;
  logic [4:0]  frame_d;
  logic [1:0]  low_q;
  logic [1:0]  low_d;
  logic        mode_q;
  logic        mode_d;
  logic        oe_q;
  logic        oe_d;
  logic        do_q;
  logic        do_d;
  logic        load_rep;
  logic [16:1] rep_q;
  logic        smi_q;

  // ==========================================================================
  // Slot sources
  assign en           = irq_routing_config_reg_i[sirq_pkg::EN_BIT];
  assign line         = sirq.line;
  assign smi_to_frame = smi_enable2_i[sirq_pkg::SMI_FRAME_BIT];

  // Slot one is never driven, so its level is pinned high.
  assign lvl[1]    = 1'b1;
  assign lvl[2]    = irq_i[1];
  assign lvl[3]    = smi_to_frame ? system_mgmt_interrupt_n_i : irq_i[2];
  assign lvl[16:4] = irq_i[15:3];

  // A slot differs from what was last reported: a report is owed.
  // Changes after their slot was sampled stay here until the next cycle.
  assign pend = |(lvl ^ rep_q);

  // Only from idle, only in quiet mode, and only once per request.
  assign start_ok = en & mode_q & pend & ~oe_q;

  assign frame_n   = sirq_pkg::frame_inc(frame_q);
  assign slot_hit  = (phase_q == sirq_pkg::PH_T) && (frame_n <= sirq_pkg::SLOT_LAST);
  assign stop_seen = line && (low_q >= sirq_pkg::STOP_QUIET);
  assign low_inc   = (low_q == sirq_pkg::LOW_SAT) ? sirq_pkg::LOW_SAT : low_q + 2'h1;

  // A stop of three or more low clocks selects continuous mode.
  assign stop_quiet = (low_q == sirq_pkg::STOP_QUIET);
  // Recovery high only follows our own low, so we never fight another agent's slot.
  assign recover    = (phase_q == sirq_pkg::PH_S) && oe_q;
  // The enable gates the drive at the flop, so clearing it mid-slot releases at the next clock.
  assign oe_gated   = oe_d & en;
  // Nothing counts as reported while disabled: changes stay owed until enabled.
  assign rep_we     = load_rep & en;
  assign smi_to_pin = smi_enable2_i[sirq_pkg::SMI_PIN_BIT];
  assign smi_d      = ~(smi_to_pin & ~system_mgmt_interrupt_n_i);

  // ==========================================================================
  // Cycle tracking and drive decision for the next clock
  always_comb begin
    state_d  = state_q;
    phase_d  = phase_q;
    frame_d  = frame_q;
    low_d    = low_q;
    mode_d   = mode_q;
    oe_d     = 1'b0;
    do_d     = 1'b0;
    load_rep = 1'b0;
    unique case (state_q)
      sirq_pkg::SL_IDLE: begin
        // Idle is entered at the stop rise, so a start lands two clocks later.
        if (!line) begin
          state_d = sirq_pkg::SL_START;
        end else if (start_ok) begin
          oe_d = 1'b1;
        end
      end
      sirq_pkg::SL_START: begin
        // The host's high clock is clock zero; frame counting starts after it.
        if (line) begin
          state_d = sirq_pkg::SL_FRAMES;
          phase_d = sirq_pkg::PH_T;
          frame_d = 5'h00;
          low_d   = 2'h0;
        end
      end
      sirq_pkg::SL_FRAMES: begin
        phase_d = sirq_pkg::next_phase(phase_q);
        if (phase_q == sirq_pkg::PH_T) begin
          frame_d = frame_n;
        end
        low_d = line ? 2'h0 : low_inc;
        if (stop_seen) begin
          state_d = sirq_pkg::SL_IDLE;
          mode_d  = stop_quiet;
        end else if (slot_hit) begin
          oe_d     = ~lvl[frame_n];
          load_rep = 1'b1;
        end else if (recover) begin
          oe_d = 1'b1;
          do_d = 1'b1;
        end
      end
      default: begin
        state_d = sirq_pkg::SL_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= sirq_pkg::SL_IDLE;
      phase_q <= sirq_pkg::PH_T;
      frame_q <= 5'h00;
      low_q   <= 2'h0;
      mode_q  <= 1'b0;
      oe_q    <= 1'b0;
      do_q    <= 1'b0;
      rep_q   <= 16'hFFFF;
      smi_q   <= 1'b1;
    end else if (ce_i) begin
      state_q <= state_d;
      phase_q <= phase_d;
      frame_q <= frame_d;
      low_q   <= low_d;
      mode_q  <= mode_d;
      oe_q    <= oe_gated;
      do_q    <= do_d;
      if (rep_we) begin
        rep_q[frame_n] <= lvl[frame_n];
      end
      smi_q <= smi_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign sirq.slv_oe        = oe_q;
  assign sirq.slv_do        = do_q;
  assign smi_output_pin_n_o = smi_q;
  assign quiet_mode_o       = mode_q;
  assign cycle_active_o     = (state_q != sirq_pkg::SL_IDLE);

endmodule

`default_nettype wire

// ==== sim/sirq_properties.sv ====
// Concurrent checks on the shared serial interrupt line.
// Assumes it sits beside the interface that joins the two ends.
`default_nettype none

module sirq_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Line drivers and level
  input wire logic slv_oe,
  input wire logic slv_do,
  input wire logic host_oe,
  input wire logic host_do,
  input wire logic line
);
  // ==========================================================================
  // Helpers
  wire logic slv_lo  = slv_oe & ~slv_do;
  wire logic host_lo = host_oe & ~host_do;
  wire logic host_hi = host_oe & host_do;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A long host low marks a start, never a stop.
  sequence start_end_s; host_lo [*4] ##1 host_hi; endsequence
  sequence slv_start_s; slv_lo ##1 host_lo; endsequence

  // ==========================================================================
  // Assertions
  reset_release_a: assert property (disable iff (1'b0)
    rst_i |-> !slv_oe && !host_oe) else $error("line driven in reset");
  start_one_a: assert property (slv_start_s |-> !slv_oe)
    else $error("slave start not one clock");
  recovery_high_a: assert property (slv_lo ##1 !host_oe |-> slv_oe && slv_do)
    else $error("no recovery high");
  turnaround_release_a: assert property (slv_oe && slv_do |=> !slv_oe)
    else $error("no release at turnaround");
  slot_gap_a: assert property (slv_lo |=> !slv_lo [*2])
    else $error("slots closer than three clocks");
  slot_unused_a: assert property (start_end_s |-> ##2 !slv_lo)
    else $error("first slot driven");
  line_low_max_a: assert property (!line [*8] |=> line)
    else $error("line low over eight clocks");
  host_high_a: assert property (host_lo ##1 !host_lo |-> host_hi)
    else $error("host low not ended high");
  host_release_a: assert property (host_hi |=> !host_oe)
    else $error("host high over one clock");
endmodule

`default_nettype wire

// ==== sim/serial_irq_slave_agent_tb.sv ====
// Self-checking bench: host end and device end joined by the line.
// Assumes a single 50 MHz clock and the register map of the host end.
`default_nettype none

module serial_irq_slave_agent_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [15:1] irq = 15'h7FFF;
  logic        smi_n = 1'b1;
  logic [7:0]  cfg = 8'h80;
  logic [7:0]  en2 = 8'h00;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [17:1] irq_levels_o;
  logic        cycle_done_o;
  logic        smi_pin_n;
  logic        quiet_mode_o;
  logic        slv_active;
  logic [31:0] q;
  logic        s;
  int          fail_count = 0;
  int          checks_done = 0;
  int          ticks = 0;

  always #10 clk_i = ~clk_i;

  sirq_if i_sirq_if ();
  sirq_slave i_sirq_slave (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .irq_routing_config_reg_i(cfg),
    .smi_enable2_i(en2), .irq_i(irq), .system_mgmt_interrupt_n_i(smi_n), .smi_output_pin_n_o(smi_pin_n),
    .quiet_mode_o(quiet_mode_o), .cycle_active_o(slv_active), .sirq(i_sirq_if.slave));
  sirq_host i_sirq_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_levels_o(irq_levels_o),
    .cycle_done_o(cycle_done_o), .sirq(i_sirq_if.host));
  sirq_properties i_sirq_properties (.clk_i(clk_i), .rst_i(rst_i), .slv_oe(i_sirq_if.slv_oe),
    .slv_do(i_sirq_if.slv_do), .host_oe(i_sirq_if.host_oe), .host_do(i_sirq_if.host_do),
    .line(i_sirq_if.line));

  // ==========================================================================
  // Shared tasks
  task automatic close_out();
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Called just after a rising edge; waitrequest and read data are taken at the edge that ends the transfer.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
    logic w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    w = 1'b1;
    rd = 32'h0;
    while (w) begin
      @(posedge clk_i);
      w = avs_waitrequest_o;
      rd = avs_readdata_o;
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_done(input int lim, output logic seen);
    seen = 1'b0;
    repeat (lim) if (!seen) begin
      @(negedge clk_i);
      seen = (cycle_done_o === 1'b1);
    end
    @(posedge clk_i);
  endtask

  function automatic logic [17:1] exp_lv();
    exp_lv = {1'b1, irq[15:3], (en2[sirq_pkg::SMI_FRAME_BIT] ? smi_n : irq[2]), irq[1], 1'b1};
    if (!cfg[sirq_pkg::EN_BIT])
      exp_lv = '1;
  endfunction

  task automatic cycle_chk(input logic [31:0] ctrl);
    bus(1'b1, sirq_pkg::REG_CTRL, ctrl, q);
    wait_done(120, s);
    check("cycle_done", 32'(s), 32'h1);
    check("levels", 32'(irq_levels_o), 32'(exp_lv()));
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_frames();
    logic [15:1] pats [2];
    pats = '{15'h5A3C, 15'h6FFF};
    foreach (pats[i]) begin
      irq <= pats[i];
      repeat (2) @(posedge clk_i);
      cycle_chk(32'h31);
    end
    bus(1'b0, sirq_pkg::REG_LEVELS, 32'h0, q);
    check("levels_reg", q, {14'h0, exp_lv(), 1'b0});
    bus(1'b0, 4'hC, 32'h0, q);
    check("unmapped", q, 32'h0);
  endtask

  task automatic t_smi();
    en2 <= 8'hC0;
    smi_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    cycle_chk(32'h31);
    check("smi_pin", 32'(smi_pin_n), 32'h0);
    en2 <= 8'h40;
    repeat (3) @(posedge clk_i);
    check("smi_pin_off", 32'(smi_pin_n), 32'h1);
    en2 <= 8'h00;
    smi_n <= 1'b1;
  endtask

  task automatic t_quiet();
    cycle_chk(32'h33);
    check("quiet_slave", 32'(quiet_mode_o), 32'h1);
    bus(1'b0, sirq_pkg::REG_STATUS, 32'h0, q);
    check("quiet_host", 32'(q[sirq_pkg::STAT_QUIET]), 32'h1);
    irq[1] <= ~irq[1];
    wait_done(150, s);
    check("slave_start", 32'(s), 32'h1);
    check("levels_q", 32'(irq_levels_o), 32'(exp_lv()));
    cycle_chk(32'h31);
    check("cont_slave", 32'(quiet_mode_o), 32'h0);
    irq[2] <= ~irq[2];
    wait_done(150, s);
    check("no_start", 32'(s), 32'h0);
  endtask

  // A change after its slot was sampled must wait for the following cycle.
  task automatic t_pending();
    logic old;
    old = irq[1];
    bus(1'b1, sirq_pkg::REG_CTRL, 32'h31, q);
    repeat (40) @(posedge clk_i);
    check("slave_active", 32'(slv_active), 32'h1);
    irq[1] <= ~old;
    wait_done(120, s);
    check("slave_idle", 32'(slv_active), 32'h0);
    check("late_kept", 32'(irq_levels_o[2]), 32'(old));
    cycle_chk(32'h31);
  endtask

  task automatic t_enable();
    cfg <= 8'h00;
    irq <= 15'h0000;
    repeat (2) @(posedge clk_i);
    cycle_chk(32'h31);
    cfg <= 8'h80;
  endtask

  // ==========================================================================
  // Main sequence and timeout
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 20000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    check("line_reset", 32'(i_sirq_if.line), 32'h1);
    check("mode_reset", 32'(quiet_mode_o), 32'h0);
    check("levels_reset", 32'(irq_levels_o), 32'h1FFFF);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_done(120, s);
    check("initial_cycle", 32'(s), 32'h1);
    check("initial_levels", 32'(irq_levels_o), 32'(exp_lv()));
    t_frames();
    t_smi();
    t_quiet();
    t_pending();
    t_enable();
    close_out();
  end
endmodule

`default_nettype wire
